// File: verilog/sms_defs.svh
// Timing and reset constants of the mode supervisor.
// Assumes a 40 MHz system clock; included by the supervisor module.
`ifndef SMS_DEFS_SVH
`define SMS_DEFS_SVH
`define SMS_CLK_KHZ        40000
`define SMS_CLK_NS         25
// Normal Request window
`define SMS_T_NREQ_MS      350
`define SMS_NREQ_CYC       (`SMS_T_NREQ_MS * `SMS_CLK_KHZ)
// Shortest watchdog period, doubled per select step
`define SMS_T_WD_BASE_MS   10
`define SMS_WD_BASE_CYC    (`SMS_T_WD_BASE_MS * `SMS_CLK_KHZ)
// Wake-up pulse on the interrupt output
`define SMS_T_INTP_NS      10000
`define SMS_INTP_CYC       (`SMS_T_INTP_NS / `SMS_CLK_NS)
// Reset hold time
`define SMS_T_RSTHOLD_US   1
`define SMS_RSTHOLD_CYC    ((`SMS_T_RSTHOLD_US * `SMS_CLK_KHZ) / 1000)
// Cyclic switch pulsing in low-power modes
`define SMS_T_CYC_PER_MS   20
`define SMS_CYC_PER_CYC    (`SMS_T_CYC_PER_MS * `SMS_CLK_KHZ)
`define SMS_T_CYC_ON_US    100
`define SMS_CYC_ON_CYC     ((`SMS_T_CYC_ON_US * `SMS_CLK_KHZ) / 1000)
// Reset values of configuration
`define SMS_WD_SEL_RST     2'h0
`define SMS_WD_WIN_RST     1'h1
`define SMS_IEN_RST        3'h0
// Command word fields
`define SMS_OP_MSB         7
`define SMS_OP_LSB         5
`define SMS_ARG_TGT        4
`define SMS_ARG_WIN        3
`endif

// File: verilog/sms_pkg.sv
// Types of the mode supervisor: operating modes and serial command codes.
// Assumes nothing of its surroundings.
package sms_pkg;
	typedef enum logic [2:0] {
		md_reset   = 3'b000,
		md_nreq    = 3'b001,
		md_normal  = 3'b010,
		md_standby = 3'b011,
		md_stop    = 3'b100,
		md_sleep   = 3'b101
	} sms_mode_t;

	typedef enum logic [2:0] {
		op_mode  = 3'b000,
		op_wdcfg = 3'b001,
		op_wdclr = 3'b010,
		op_ctrl  = 3'b011,
		op_ien   = 3'b100,
		op_clr   = 3'b101
	} sms_op_t;
endpackage : sms_pkg

// File: verilog/sms_mode_supervisor.sv
// Mode sequencer, watchdog, reset and interrupt logic of the supervisor.
// Assumes analog comparators on pins, a serial host on sclk/cs_n/mosi.
// Notes on behaviour
// RULE_01 - Reset output low throughout Reset mode, high in every other mode.
// RULE_02 - Main regulator undervoltage pulls the reset output low; the code ignores it in Sleep mode.
// RULE_03 - Thermal warning sets a flag; thermal shutdown turns main regulator off.
// RULE_04 - Enabled interrupt source holds interrupt output low until cleared.
// RULE_05 - Wake-up from Stop gives one 10 us low pulse on interrupt.
// RULE_06 - Wake inputs readable; they wake the device from Sleep or Stop.
// RULE_07 - Watchdog fault output low while watchdog not serviced correctly.
// RULE_08 - Battery below 3.0 V latches a supply-loss flag in every mode.
// RULE_09 - Battery below 6.0 V flagged with hysteresis, Normal/Standby only, maskable.
// RULE_10 - Aux-supply-low bit is one while aux regulator below 4.5 V.
// RULE_11 - Switch overtemperature shuts switch, sets status and combined fault flag.
// RULE_12 - Switch under command; pulsed in Sleep/Stop, continuous in Normal/Standby.
// RULE_13 - Precise oscillator in Normal Request/Normal/Standby, coarse in Sleep/Stop.
// RULE_14 - Host selects main modes; Normal Request entered automatically.
// RULE_15 - Standby: main regulator only, aux drive off, watchdog running.
// RULE_16 - Normal: both regulators and CAN on; host clears watchdog periodically.
// RULE_17 - Stop watchdog runs per stop-watchdog bit; host wakes via chip select.
// RULE_18 - Stop wakes on listed events straight into Normal Request.
// RULE_19 - Sleep: regulators off; wake goes through Reset to Normal Request.
// RULE_20 - Reset on power-up, undervoltage, watchdog timeout or early service; the code takes no undervoltage reset in Sleep.
// RULE_21 - Normal Request: 350 ms timer; watchdog config selects Normal/Standby.
// RULE_22 - Host writes watchdog config before the 350 ms window ends.
// RULE_23 - Window expiry goes to Reset, or back to Sleep if from Sleep.
// RULE_24 - Stop entered at chip-select rise ending the command; rise wakes.
`timescale 1ns/10ps
`include "sms_defs.svh"

module sms_mode_supervisor import sms_pkg::*; #(
	parameter int unsigned NREQ_CYC    = `SMS_NREQ_CYC,
	parameter int unsigned WD_BASE_CYC = `SMS_WD_BASE_CYC,
	parameter int unsigned CYC_PER_CYC = `SMS_CYC_PER_CYC
) (
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic       sclk,
	input  wire logic       cs_n,
	input  wire logic       mosi,
	input  wire logic       main_uv,
	input  wire logic       main_ot_warn,
	input  wire logic       main_ot_shut,
	input  wire logic       main_overcurrent,
	input  wire logic       batt_loss,
	input  wire logic       batt_low,
	input  wire logic       batt_ok,
	input  wire logic       aux_low,
	input  wire logic       switch_ot,
	input  wire logic       can_wake,
	input  wire logic       forced_wake,
	input  wire logic       cyclic_wake,
	input  wire logic [3:0] wake_inputs,
	output logic            rst_n_out,
	output logic            int_n_out,
	output logic            watchdog_fault_out_n,
	output logic            main_regulator_en,
	output logic            aux_ballast_drive,
	output logic            can_en,
	output logic            battery_switch_out,
	output logic            osc_precise_sel,
	output logic [2:0]      mode_out,
	output logic            supply_loss_flag,
	output logic            main_reg_thermal_flag,
	output logic            batt_low_flag,
	output logic            aux_supply_low_flag,
	output logic            switch_overtemp_flag,
	output logic            switch_or_aux_fault_flag,
	output logic [3:0]      wake_inputs_state
);
	// Link side: command shifter on the host's serial clock
	logic [2:0]  bit_cnt_r;
	logic [6:0]  shift_r;
	logic [7:0]  word_r;
	logic        tog_r;
	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			bit_cnt_r <= 3'h0;
			shift_r   <= 7'h00;
		end else begin
			bit_cnt_r <= bit_cnt_r + 3'h1;
			shift_r   <= {shift_r[5:0], mosi};
		end
	end
	always_ff @(posedge sclk or posedge srst) begin
		if (srst) begin
			word_r <= 8'h00;
			tog_r  <= 1'b0;
		end else if (!cs_n && bit_cnt_r == 3'h7) begin
			word_r <= {shift_r, mosi};
			tog_r  <= !tog_r;
		end
	end

	// Pin synchronisers; stage 1 is read only by stage 2
	localparam int NSYNC = 18;
	logic [NSYNC-1:0] raw;
	logic [NSYNC-1:0] s1_r;
	logic [NSYNC-1:0] s2_r;
	logic [NSYNC-1:0] s3_r;
	assign raw = {tog_r, cs_n, wake_inputs, cyclic_wake, forced_wake, can_wake,
		switch_ot, aux_low, batt_ok, batt_low, batt_loss, main_overcurrent,
		main_ot_shut, main_ot_warn, main_uv};
	always_ff @(posedge clk) begin
		s1_r <= raw;
		s2_r <= s1_r;
		s3_r <= s2_r;
	end

	logic uv, ot_warn, ot_shut, ovc, b_loss, b_low, b_ok, a_low, sw_ot;
	logic w_can, w_forced, w_cyc, cs_hi, cs_rise, cmd_v, wk_edge;
	assign {w_cyc, w_forced, w_can, sw_ot, a_low, b_ok, b_low, b_loss, ovc, ot_shut, ot_warn, uv} = s2_r[11:0];
	assign wk_edge  = s2_r[15:12] != s3_r[15:12];
	assign cs_hi    = s2_r[16];
	assign cs_rise  = s2_r[16] && !s3_r[16];
	assign cmd_v    = (s2_r[17] != s3_r[17]) && !srst;

	// Command decode; the word stays stable until the eighth sclk edge after the toggle
	sms_op_t    op;
	logic [4:0] arg;
	logic       c_mode, c_cfg, c_clr, c_ctrl, c_ien, c_fclr;
	assign op     = sms_op_t'(word_r[`SMS_OP_MSB:`SMS_OP_LSB]);
	assign arg    = word_r[4:0];
	assign c_mode = cmd_v && op == op_mode;
	assign c_cfg  = cmd_v && op == op_wdcfg;
	assign c_clr  = cmd_v && op == op_wdclr;
	assign c_ctrl = cmd_v && op == op_ctrl;
	assign c_ien  = cmd_v && op == op_ien;
	assign c_fclr = cmd_v && op == op_clr;

	// Configuration written by the host
	logic [1:0] wd_sel_r;
	logic       wd_win_r, sw_on_r, stop_wd_en_r;
	logic [2:0] ien_r;

	always_ff @(posedge clk) begin
		if (srst) begin
			wd_sel_r <= `SMS_WD_SEL_RST;
			wd_win_r <= `SMS_WD_WIN_RST;
		end else if (c_cfg) begin
			wd_sel_r <= arg[1:0];
			wd_win_r <= arg[`SMS_ARG_WIN];
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			sw_on_r      <= 1'b0;
			stop_wd_en_r <= 1'b0;
		end else if (c_ctrl) begin
			sw_on_r      <= arg[0];
			stop_wd_en_r <= arg[1];
		end
	end

	always_ff @(posedge clk) begin
		if (srst)
			ien_r <= `SMS_IEN_RST;
		else if (c_ien)
			ien_r <= arg[2:0];
	end

	// Mode sequencer
	sms_mode_t mode_r, mode_nxt;
	logic [31:0] tmr_r, wd_cnt_r, wd_per;
	logic        from_sleep_r, stop_pend_r, wd_run, wd_tmo, wd_early, wd_good;
	logic        run_mode, stop_wake, sleep_wake;

	assign run_mode   = mode_r == md_normal || mode_r == md_standby;
	assign stop_wake  = w_cyc || w_forced || w_can || wk_edge || ovc || cs_rise;
	assign sleep_wake = w_cyc || w_forced || w_can || wk_edge;
	always_comb begin
		mode_nxt = mode_r;
		unique case (mode_r)
			md_reset:
				if (!uv && tmr_r >= `SMS_RSTHOLD_CYC - 1)
					mode_nxt = md_nreq; // see RULE_20
			md_nreq:
				if (c_cfg)
					mode_nxt = arg[`SMS_ARG_TGT] ? md_standby : md_normal; // see RULE_21
				else if (tmr_r >= NREQ_CYC - 1)
					mode_nxt = from_sleep_r ? md_sleep : md_reset; // see RULE_23
			md_normal, md_standby:
				if (wd_tmo || wd_early)
					mode_nxt = md_reset; // see RULE_20
				else if (stop_pend_r && cs_hi)
					mode_nxt = md_stop; // see RULE_24
				else if (c_mode && arg[1:0] == 2'h0)
					mode_nxt = md_normal; // see RULE_14
				else if (c_mode && arg[1:0] == 2'h1)
					mode_nxt = md_standby;
				else if (c_mode && arg[1:0] == 2'h3)
					mode_nxt = md_sleep;
			md_stop:
				if (wd_tmo)
					mode_nxt = md_reset; // see RULE_17
				else if (stop_wake)
					mode_nxt = md_nreq; // see RULE_18
			md_sleep:
				if (sleep_wake)
					mode_nxt = md_reset; // see RULE_19
			default:
				mode_nxt = md_reset;
		endcase
		if (uv && mode_r != md_sleep)
			mode_nxt = md_reset; // see RULE_02
	end

	always_ff @(posedge clk) begin
		if (srst)
			mode_r <= md_reset;
		else
			mode_r <= mode_nxt;
	end

	always_ff @(posedge clk) begin
		if (srst || mode_nxt != mode_r)
			tmr_r <= 32'h0;
		else
			tmr_r <= tmr_r + 32'h1;
	end

	always_ff @(posedge clk) begin
		if (srst)
			from_sleep_r <= 1'b0;
		else if (mode_r == md_sleep && mode_nxt == md_reset)
			from_sleep_r <= 1'b1;
		else if (mode_nxt == md_normal || mode_nxt == md_standby)
			from_sleep_r <= 1'b0;
	end

	always_ff @(posedge clk) begin
		if (srst || !run_mode || mode_nxt != mode_r)
			stop_pend_r <= 1'b0;
		else if (c_mode && arg[1:0] == 2'h2)
			stop_pend_r <= 1'b1;
	end

	// Watchdog
	assign wd_per   = WD_BASE_CYC << wd_sel_r;
	assign wd_run   = run_mode || (mode_r == md_stop && stop_wd_en_r); // see RULE_15
	assign wd_tmo   = wd_run && wd_cnt_r >= wd_per - 32'h1;
	assign wd_early = run_mode && c_clr && wd_win_r && wd_cnt_r < (wd_per >> 1);
	assign wd_good  = c_cfg || (c_clr && !wd_early);

	always_ff @(posedge clk) begin
		if (srst || !wd_run || wd_good || wd_tmo || mode_nxt != mode_r)
			wd_cnt_r <= 32'h0;
		else
			wd_cnt_r <= wd_cnt_r + 32'h1; // see RULE_16
	end

	always_ff @(posedge clk) begin
		if (srst)
			watchdog_fault_out_n <= 1'b1;
		else if (wd_tmo || wd_early)
			watchdog_fault_out_n <= 1'b0; // see RULE_07
		else if (wd_good)
			watchdog_fault_out_n <= 1'b1;
	end

	// Reset output
	always_ff @(posedge clk) begin
		if (srst)
			rst_n_out <= 1'b0;
		else
			rst_n_out <= mode_nxt != md_reset; // see RULE_01
	end

	// Supply and thermal flags; a set beats a clear in the same cycle
	logic [2:0] iflags_r;
	logic [2:0] iset;
	logic       bl_set;
	assign bl_set = run_mode && b_low && !batt_low_flag;
	assign iset   = {sw_ot || a_low, bl_set, ot_warn}; // see RULE_11

	always_ff @(posedge clk) begin
		if (srst)
			iflags_r <= 3'h0;
		else
			iflags_r <= (iflags_r & ~({3{c_fclr}} & arg[2:0])) | iset; // see RULE_03
	end

	always_ff @(posedge clk) begin
		if (srst)
			supply_loss_flag <= 1'b0;
		else
			supply_loss_flag <= b_loss || (supply_loss_flag && !(c_fclr && arg[3])); // see RULE_08
	end

	always_ff @(posedge clk) begin
		if (srst)
			batt_low_flag <= 1'b0;
		else if (bl_set)
			batt_low_flag <= 1'b1; // see RULE_09
		else if (run_mode && b_ok)
			batt_low_flag <= 1'b0;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			aux_supply_low_flag  <= 1'b0;
			switch_overtemp_flag <= 1'b0;
			wake_inputs_state    <= 4'h0;
		end else begin
			aux_supply_low_flag  <= a_low; // see RULE_10
			switch_overtemp_flag <= sw_ot;
			wake_inputs_state    <= s2_r[15:12]; // see RULE_06
		end
	end

	assign main_reg_thermal_flag    = iflags_r[0];
	assign switch_or_aux_fault_flag = iflags_r[2];

	// Interrupt output: level for enabled flags, pulse for Stop wake-up
	logic [8:0] pcnt_r;
	always_ff @(posedge clk) begin
		if (srst)
			pcnt_r <= 9'h0;
		else if (mode_r == md_stop && mode_nxt == md_nreq)
			pcnt_r <= 9'(`SMS_INTP_CYC); // see RULE_05
		else if (pcnt_r != 9'h0)
			pcnt_r <= pcnt_r - 9'h1;
	end

	always_ff @(posedge clk) begin
		if (srst)
			int_n_out <= 1'b1;
		else
			int_n_out <= !((|(iflags_r & ien_r)) || pcnt_r != 9'h0); // see RULE_04
	end

	// Supply, switch and oscillator controls
	logic [31:0] cyc_r;
	always_ff @(posedge clk) begin
		if (srst || cyc_r >= CYC_PER_CYC - 1)
			cyc_r <= 32'h0;
		else
			cyc_r <= cyc_r + 32'h1;
	end

	logic low_nxt, run_nxt;
	assign low_nxt = mode_nxt == md_sleep || mode_nxt == md_stop;
	assign run_nxt = mode_nxt == md_normal || mode_nxt == md_standby;

	always_ff @(posedge clk) begin
		if (srst) begin
			main_regulator_en  <= 1'b0;
			aux_ballast_drive  <= 1'b0;
			can_en             <= 1'b0;
			osc_precise_sel    <= 1'b1;
			battery_switch_out <= 1'b0;
			mode_out           <= 3'h0;
		end else begin
			main_regulator_en  <= mode_nxt != md_sleep && !ot_shut; // see RULE_03
			aux_ballast_drive  <= mode_nxt == md_normal; // see RULE_15
			can_en             <= mode_nxt == md_normal; // see RULE_16
			osc_precise_sel    <= !low_nxt; // see RULE_13
			battery_switch_out <= sw_on_r && !sw_ot &&
				(run_nxt || (low_nxt && cyc_r < `SMS_CYC_ON_CYC)); // see RULE_12
			mode_out           <= mode_nxt;
		end
	end

	// Checks
	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	sequence s_stop_woken;
		mode_r == md_stop && mode_nxt == md_nreq;
	endsequence

	sequence s_int_pulse;
		##2 !int_n_out [*8];
	endsequence

	a_rst_in_reset: assert property (mode_r == md_reset |-> !rst_n_out) // see RULE_01
		else $error("reset output high in reset mode");
	a_uv_forces_reset: assert property (uv && mode_r != md_sleep |=> mode_r == md_reset) // see RULE_02
		else $error("undervoltage did not force reset mode");
	a_int_pulse_low: assert property (s_stop_woken |-> s_int_pulse) // see RULE_05
		else $error("no interrupt pulse after stop wake");
	a_int_level_hold: assert property (|(iflags_r & ien_r) |=> !int_n_out) // see RULE_04
		else $error("enabled flag did not hold interrupt low");
	a_wd_fault_low: assert property (wd_tmo |=> !watchdog_fault_out_n && mode_r == md_reset) // see RULE_07
		else $error("watchdog timeout not flagged");
	a_supply_loss_set: assert property (b_loss |=> supply_loss_flag) // see RULE_08
		else $error("supply loss flag not latched");
	a_batt_low_modes: assert property (!run_mode |=> $stable(batt_low_flag)) // see RULE_09
		else $error("battery low flag moved outside run modes");
	a_switch_ot_off: assert property (sw_ot |=> !battery_switch_out) // see RULE_11
		else $error("switch on during overtemperature");
	a_sleep_via_reset: assert property (mode_r == md_sleep && sleep_wake |=> mode_r == md_reset ##1 !rst_n_out) // see RULE_19
		else $error("sleep wake skipped reset mode");
	a_nreq_config: assert property (mode_r == md_nreq && c_cfg && !uv
		|=> (mode_r == md_normal || mode_r == md_standby) ##1 rst_n_out) // see RULE_21
		else $error("config did not leave normal request");
	a_osc_select: assert property ($past(low_nxt) == !osc_precise_sel) // see RULE_13
		else $error("oscillator select wrong for mode");
endmodule : sms_mode_supervisor

// File: verif/sms_host.sv
// Host microcontroller model on the serial command link.
// Assumes the supervisor samples mosi on the rising sclk edge while cs_n is low.
`timescale 1ns/10ps

module sms_host (
	output logic sclk,
	output logic cs_n,
	output logic mosi
);
	localparam time HALF = 40ns;

	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
	end

	// One word, MSB first; sclk only runs inside the frame
	task automatic send_word(input logic [7:0] w);
		cs_n = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			mosi = w[i];
			#HALF sclk = 1'b1;
			#HALF sclk = 1'b0;
		end
		#HALF cs_n = 1'b1;
		// Deselected line must not keep showing the last bit
		mosi = ~mosi;
		#(4 * HALF);
	endtask : send_word

	// Chip-select pulse with no clocks, used as a wake-up from Stop
	task automatic cs_wake();
		cs_n = 1'b0;
		#(2 * HALF) cs_n = 1'b1;
	endtask : cs_wake
endmodule : sms_host

// File: verif/sms_mode_supervisor_tb.sv
// Self-checking bench of the mode supervisor with a host model.
// Assumes shortened timer parameters; reset hold, wake pulse and switch-on time keep their defined lengths.
`timescale 1ns/10ps

module sms_mode_supervisor_tb import sms_pkg::*;;
	logic       clk, srst, sclk, cs_n, mosi;
	logic       main_uv, main_ot_warn, main_ot_shut, batt_loss, batt_low, batt_ok;
	logic       aux_low, switch_ot, can_wake, main_overcurrent, forced_wake, cyclic_wake;
	logic [3:0] wake_inputs, wake_inputs_state;
	logic       rst_n_out, int_n_out, watchdog_fault_out_n, main_regulator_en, aux_ballast_drive;
	logic       can_en, battery_switch_out, osc_precise_sel, supply_loss_flag, main_reg_thermal_flag;
	logic       batt_low_flag, aux_supply_low_flag, switch_overtemp_flag, switch_or_aux_fault_flag;
	logic [2:0] mode_out;
	int         num_errors = 0;
	int         cmp_count = 0;

	sms_host HOST (.sclk(sclk), .cs_n(cs_n), .mosi(mosi));

	sms_mode_supervisor #(.NREQ_CYC(200), .WD_BASE_CYC(100), .CYC_PER_CYC(5000)) DUT (
		.clk(clk), .srst(srst), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .main_uv(main_uv),
		.main_ot_warn(main_ot_warn), .main_ot_shut(main_ot_shut), .main_overcurrent(main_overcurrent),
		.batt_loss(batt_loss), .batt_low(batt_low), .batt_ok(batt_ok), .aux_low(aux_low),
		.switch_ot(switch_ot), .can_wake(can_wake), .forced_wake(forced_wake), .cyclic_wake(cyclic_wake),
		.wake_inputs(wake_inputs), .rst_n_out(rst_n_out), .int_n_out(int_n_out),
		.watchdog_fault_out_n(watchdog_fault_out_n), .main_regulator_en(main_regulator_en),
		.aux_ballast_drive(aux_ballast_drive), .can_en(can_en), .battery_switch_out(battery_switch_out),
		.osc_precise_sel(osc_precise_sel), .mode_out(mode_out), .supply_loss_flag(supply_loss_flag),
		.main_reg_thermal_flag(main_reg_thermal_flag), .batt_low_flag(batt_low_flag),
		.aux_supply_low_flag(aux_supply_low_flag), .switch_overtemp_flag(switch_overtemp_flag),
		.switch_or_aux_fault_flag(switch_or_aux_fault_flag), .wake_inputs_state(wake_inputs_state)
	);

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic end_sim();
		$display("Counts: errors=%0d checks=%0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_sim

	task automatic chk(input logic ok, input string msg);
		cmp_count++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("BAD %0t %s", $time, msg);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc

	task automatic wait_mode(input sms_mode_t m, input int lim);
		int n;
		n = 0;
		while (mode_out !== m && n < lim) begin
			@(negedge clk);
			n++;
		end
		chk(mode_out === m, "mode not reached in time");
	endtask : wait_mode

	task automatic do_reset();
		srst = 1'b1;
		cyc(3);
		srst = 1'b0;
	endtask : do_reset

	// Reset, then configure the watchdog to leave Normal Request
	task automatic to_mode(input logic [7:0] cfg, input sms_mode_t m);
		do_reset();
		wait_mode(md_nreq, 100);
		HOST.send_word(cfg);
		wait_mode(m, 60);
	endtask : to_mode

	task automatic t_reset_seq();
		do_reset();
		cyc(2);
		chk(rst_n_out === 1'b0 && mode_out === md_reset, "reset low in Reset mode");
		wait_mode(md_nreq, 100);
		chk(rst_n_out === 1'b1 && main_regulator_en === 1'b1, "nreq outputs");
		chk(aux_ballast_drive === 1'b0 && osc_precise_sel === 1'b1, "nreq aux/osc");
		wait_mode(md_reset, 250);
	endtask : t_reset_seq

	task automatic t_normal_wd();
		to_mode(8'h23, md_normal);
		chk(aux_ballast_drive === 1'b1 && can_en === 1'b1, "normal outputs");
		wait_mode(md_reset, 900);
		chk(watchdog_fault_out_n === 1'b0 && rst_n_out === 1'b0, "watchdog timeout");
		wait_mode(md_nreq, 100);
		HOST.send_word(8'h23);
		wait_mode(md_normal, 60);
		chk(watchdog_fault_out_n === 1'b1, "fault kept after config");
	endtask : t_normal_wd

	task automatic t_window();
		to_mode(8'h2b, md_normal);
		HOST.send_word(8'h40);
		wait_mode(md_reset, 60);
		chk(watchdog_fault_out_n === 1'b0, "closed-window clear");
	endtask : t_window

	task automatic t_standby();
		to_mode(8'h33, md_standby);
		chk(aux_ballast_drive === 1'b0 && main_regulator_en === 1'b1, "standby supplies");
		chk(osc_precise_sel === 1'b1, "standby oscillator");
	endtask : t_standby

	// Wake source: 0 chip select, 1 wake pins, 2 overcurrent, 3 forced, 4 cyclic
	task automatic t_stop(input int src);
		int n;
		to_mode(8'h23, md_normal);
		HOST.send_word(8'h02);
		wait_mode(md_stop, 60);
		chk(osc_precise_sel === 1'b0 && aux_ballast_drive === 1'b0, "stop outputs");
		cyc(20);
		case (src)
			0: HOST.cs_wake();
			1: wake_inputs = ~wake_inputs;
			2: main_overcurrent = 1'b1;
			3: forced_wake = 1'b1;
			default: cyclic_wake = 1'b1;
		endcase
		wait_mode(md_nreq, 30);
		{main_overcurrent, forced_wake, cyclic_wake} = 3'h0;
		n = 0;
		cyc(3);
		while (int_n_out === 1'b0 && n < 500) begin
			cyc(1);
			n++;
		end
		chk(n > 390 && n < 405, "wake pulse length");
	endtask : t_stop

	// Watchdog keeps running in Stop when enabled, and times out into Reset
	task automatic t_stop_wd();
		to_mode(8'h21, md_normal);
		HOST.send_word(8'h62);
		HOST.send_word(8'h02);
		wait_mode(md_stop, 60);
		wait_mode(md_reset, 250);
		chk(watchdog_fault_out_n === 1'b0, "stop watchdog timeout");
	endtask : t_stop_wd

	// Switch pulses in Stop; watchdog idle there by default
	task automatic t_pulse();
		int n;
		to_mode(8'h23, md_normal);
		HOST.send_word(8'h61);
		HOST.send_word(8'h02);
		wait_mode(md_stop, 60);
		n = 0;
		while (battery_switch_out !== 1'b1 && n < 1100) begin
			cyc(1);
			n++;
		end
		n = 0;
		while (battery_switch_out !== 1'b0 && n < 4100) begin
			cyc(1);
			n++;
		end
		n = 0;
		while (battery_switch_out === 1'b0 && n < 1100) begin
			cyc(1);
			n++;
		end
		chk(n > 997 && n < 1003, "switch pulse off time");
		chk(mode_out === md_stop, "stop watchdog not idle");
	endtask : t_pulse

	task automatic t_sleep();
		to_mode(8'h23, md_normal);
		HOST.send_word(8'h03);
		wait_mode(md_sleep, 60);
		chk(main_regulator_en === 1'b0 && osc_precise_sel === 1'b0, "sleep outputs");
		can_wake = 1'b1;
		wait_mode(md_reset, 20);
		can_wake = 1'b0;
		wait_mode(md_nreq, 100);
		wait_mode(md_sleep, 250);
	endtask : t_sleep

	task automatic t_irq();
		to_mode(8'h23, md_normal);
		HOST.send_word(8'h81);
		cyc(2);
		main_ot_warn = 1'b1;
		cyc(5);
		chk(main_reg_thermal_flag === 1'b1 && int_n_out === 1'b0, "thermal interrupt");
		main_ot_warn = 1'b0;
		cyc(5);
		chk(int_n_out === 1'b0, "interrupt held");
		HOST.send_word(8'ha1);
		cyc(10);
		chk(int_n_out === 1'b1, "interrupt cleared");
		main_ot_shut = 1'b1;
		cyc(5);
		chk(main_regulator_en === 1'b0, "thermal shutdown");
		main_ot_shut = 1'b0;
		to_mode(8'h23, md_normal);
		main_uv = 1'b1;
		cyc(4);
		chk(rst_n_out === 1'b0, "undervoltage reset");
		main_uv = 1'b0;
	endtask : t_irq

	task automatic t_status();
		to_mode(8'h23, md_normal);
		HOST.send_word(8'h61);
		cyc(8);
		chk(battery_switch_out === 1'b1, "switch on");
		HOST.send_word(8'h82);
		cyc(4);
		{batt_loss, aux_low, batt_low, wake_inputs} = {3'h7, 4'ha};
		cyc(5);
		batt_loss = 1'b0;
		cyc(5);
		chk(supply_loss_flag === 1'b1, "supply loss latched");
		chk(aux_supply_low_flag === 1'b1, "aux low");
		chk(batt_low_flag === 1'b1 && wake_inputs_state === 4'ha, "batt low, pins");
		chk(int_n_out === 1'b0, "batt low interrupt");
		{batt_low, batt_ok, switch_ot} = 3'h3;
		cyc(5);
		chk(batt_low_flag === 1'b0, "batt low hysteresis");
		chk(switch_overtemp_flag === 1'b1 && switch_or_aux_fault_flag === 1'b1, "switch ot");
		chk(battery_switch_out === 1'b0, "switch shut down");
		{aux_low, batt_ok, switch_ot, wake_inputs} = 7'h0;
	endtask : t_status

	initial begin
		{srst, main_uv, main_ot_warn, main_ot_shut, batt_loss, batt_low, batt_ok} = 7'h40;
		{aux_low, switch_ot, can_wake, wake_inputs} = 7'h0;
		{main_overcurrent, forced_wake, cyclic_wake} = 3'h0;
		cyc(1);
		t_reset_seq();
		t_normal_wd();
		t_window();
		t_standby();
		for (int s = 0; s < 5; s++) begin
			t_stop(s);
		end
		t_stop_wd();
		t_pulse();
		t_sleep();
		t_irq();
		t_status();
		end_sim();
	end

	initial begin
		#1ms;
		num_errors++;
		end_sim();
	end
endmodule : sms_mode_supervisor_tb
